// ===== rtl/fpei_map.vh
// Address map, field positions, reset values and constants of the
// flash programming/erasing interface. Definitions only.
`ifndef FPEI_MAP_VH
`define FPEI_MAP_VH

`define FPEI_ADDR_CCS      16'hFEA8
`define FPEI_ADDR_PCS      16'hFEA9
`define FPEI_ADDR_ECS      16'hFEAA
`define FPEI_ADDR_KEY      16'hFEAC
`define FPEI_ADDR_MATS     16'hFEAD
`define FPEI_ADDR_TDAR     16'hFEAE

`define FPEI_RST_CCS       8'h80
`define FPEI_RST_OTHER     8'h00
`define FPEI_CCS_FIXED     3'h4
`define FPEI_CCS_RSVD_LOW  3'h0
`define FPEI_SEL_RSVD      7'h00
`define FPEI_KEY_ENABLE    8'hA5

`define FPEI_BIT_REQ       0
`define FPEI_BIT_ERR       4
`define FPEI_BIT_CHOOSE    0

`define FPEI_SIZE_BYTE     2'h0

`define FPEI_COPY_CYCLES   16'h0100

`endif

// ===== rtl/fpei_err_latch.v
// Sticky flash error flag with its setting events.
// Assumes the event inputs are synchronous to sys_clk; cleared only by
// the power-on reset.
`default_nettype none
module fpei_err_latch (
    input  wire       sys_clk,
    input  wire       reset,
    input  wire       busy,
    input  wire       irq_accept,
    input  wire       array_read,
    input  wire       sleep_exec,
    output reg        err_q
);
    wire ev;
    assign ev = busy & (irq_accept | array_read | sleep_exec); // [RULE_08]

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            err_q <= 1'b0; // [RULE_07]
        end else if (ev | array_read & busy | sleep_exec & busy) begin
            err_q <= 1'b1; // [RULE_09] [RULE_10]
        end
    end
endmodule // fpei_err_latch
`default_nettype wire

// ===== rtl/fpei_copy_engine.v
// Routine download sequencer: counts the copy time and pulses done at
// the end. Assumes start is a one-cycle pulse.
`default_nettype none
`include "fpei_map.vh"
module fpei_copy_engine #(
    parameter [15:0] COPY_CYCLES = `FPEI_COPY_CYCLES
) (
    input  wire       sys_clk,
    input  wire       reset,
    input  wire       start,
    output reg        active_q,
    output reg        done_q
);
    reg [15:0] cnt_q;

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            active_q <= 1'b0;
            done_q   <= 1'b0;
            cnt_q    <= 16'h0000;
        end else begin
            done_q <= 1'b0;
            if (start && !active_q) begin
                active_q <= 1'b1;
                cnt_q    <= COPY_CYCLES;
            end else if (active_q) begin
                if (cnt_q == 16'h0001) begin
                    active_q <= 1'b0;
                    done_q   <= 1'b1;
                end
                cnt_q <= cnt_q - 16'h0001;
            end
        end
    end
endmodule // fpei_copy_engine
`default_nettype wire

// ===== rtl/fpei_top.v
// Flash programming/erasing control interface: six byte registers,
// download request, error protection.
// Operation
// [RULE_01] Control registers are eight bits and accept byte accesses only.
// [RULE_02] Reset loads 0x80 into code control status, 0x00 elsewhere.
// [RULE_03] Code control status bits other than download request are read-only.
// [RULE_04] Download request bit is writable but always reads zero.
// [RULE_05] Reserved bits 7,6,5 read 1,0,0 and ignore writes.
// [RULE_06] Error flag at bit 4 is read-only and enables protection.
// [RULE_07] Error flag reads 0 normally; only power-on reset clears it.
// [RULE_08] Accepted interrupt during programming or erasure sets the error.
// [RULE_09] Flash array read during programming or erasure sets the error.
// [RULE_10] Sleep execution during programming or erasure sets the error.
// [RULE_11] Outside reset held low 100 us after error before release.
// [RULE_12] Software uses listed registers per download or program phase.
// [RULE_13] Software sets array select before user-boot programming.
// [RULE_14] Download result byte goes to RAM start in destination register.
// [RULE_15] Software passes operating frequency in extended register zero.
// [RULE_16] Software passes program destination in extended register one.
// [RULE_17] Software passes program source in extended register zero.
// [RULE_18] Software passes erase block number in extended register zero.
// [RULE_19] While protected, further programming and erasure are refused.
// [RULE_20] Download request acts only with key 0xA5 and RAM-resident code.
// [RULE_21] Download request clears itself when the copy completes.
// [RULE_22] Software does two dummy reads and keeps interrupts off.
// [RULE_23] Select bits choose routines and clear when transfer completes.
// Assumes a synchronous CPU bus on sys_clk; bus_size 0 means a byte access.
`default_nettype none
`include "fpei_map.vh"
module fpei_top #(
    parameter [15:0] COPY_CYCLES = `FPEI_COPY_CYCLES
) (
    input  wire        sys_clk,
    input  wire        reset,
    input  wire [15:0] bus_addr,
    input  wire        bus_wr,
    input  wire        bus_rd,
    input  wire [1:0]  bus_size,
    input  wire [7:0]  bus_wdata,
    input  wire        fetch_from_ram,
    input  wire        pe_running,
    input  wire        pe_request,
    input  wire        irq_accept,
    input  wire        array_read,
    input  wire        sleep_exec,
    output reg  [7:0]  bus_rdata_q,
    output reg         bus_hit_q,
    output reg         copy_busy_q,
    output reg         copy_program_q,
    output reg         copy_erase_q,
    output reg  [7:0]  result_addr_q,
    output reg         result_we_q,
    output reg  [7:0]  result_data_q,
    output reg         pe_allow_q,
    output reg         protect_q
);
    reg  [7:0] pcs_q;
    reg  [7:0] ecs_q;
    reg  [7:0] key_q;
    reg  [7:0] mats_q;
    reg  [7:0] tdar_q;
    reg        req_q;
    reg        sel_ok_q;
    wire       err;
    wire       active;
    wire       done;
    wire       byte_acc;
    wire       wr;
    wire       start;

    // Wider accesses are ignored outright
    assign byte_acc = (bus_size == `FPEI_SIZE_BYTE); // [RULE_01]
    assign wr       = bus_wr & byte_acc;
    assign start    = wr && (bus_addr == `FPEI_ADDR_CCS)
                      && bus_wdata[`FPEI_BIT_REQ]
                      && (key_q == `FPEI_KEY_ENABLE)
                      && fetch_from_ram && !err && !active; // [RULE_20]

    fpei_err_latch u_err (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .busy       (pe_running),
        .irq_accept (irq_accept),
        .array_read (array_read),
        .sleep_exec (sleep_exec),
        .err_q      (err)
    );

    fpei_copy_engine #(
        .COPY_CYCLES (COPY_CYCLES)
    ) u_copy (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .start    (start),
        .active_q (active),
        .done_q   (done)
    );

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pcs_q    <= `FPEI_RST_OTHER; // [RULE_02]
            ecs_q    <= `FPEI_RST_OTHER;
            key_q    <= `FPEI_RST_OTHER;
            mats_q   <= `FPEI_RST_OTHER;
            tdar_q   <= `FPEI_RST_OTHER;
            req_q    <= 1'b0;
            sel_ok_q <= 1'b0;
        end else begin
            if (start) begin
                req_q    <= 1'b1;
                sel_ok_q <= pcs_q[`FPEI_BIT_CHOOSE] ^ ecs_q[`FPEI_BIT_CHOOSE];
            end else if (done) begin
                req_q <= 1'b0; // [RULE_21]
            end
            // Completion wins over a software write in the same cycle
            if (done) begin
                pcs_q[`FPEI_BIT_CHOOSE] <= 1'b0; // [RULE_23]
                ecs_q[`FPEI_BIT_CHOOSE] <= 1'b0;
            end else if (wr && !active) begin
                if (bus_addr == `FPEI_ADDR_PCS)
                    pcs_q <= {`FPEI_SEL_RSVD, bus_wdata[`FPEI_BIT_CHOOSE]};
                if (bus_addr == `FPEI_ADDR_ECS)
                    ecs_q <= {`FPEI_SEL_RSVD, bus_wdata[`FPEI_BIT_CHOOSE]};
            end
            if (wr) begin
                if (bus_addr == `FPEI_ADDR_KEY)
                    key_q <= bus_wdata;
                if (bus_addr == `FPEI_ADDR_MATS)
                    mats_q <= bus_wdata;
                if (bus_addr == `FPEI_ADDR_TDAR && !active)
                    tdar_q <= bus_wdata;
            end
        end
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            bus_rdata_q    <= 8'h00;
            bus_hit_q      <= 1'b0;
            copy_busy_q    <= 1'b0;
            copy_program_q <= 1'b0;
            copy_erase_q   <= 1'b0;
            result_addr_q  <= 8'h00;
            result_we_q    <= 1'b0;
            result_data_q  <= 8'h00;
            pe_allow_q     <= 1'b0;
            protect_q      <= 1'b0;
        end else begin
            bus_hit_q   <= 1'b0;
            bus_rdata_q <= 8'h00;
            if (bus_rd && byte_acc) begin
                bus_hit_q <= 1'b1;
                case (bus_addr)
                    // Request bit reads zero; upper bits fixed
                    `FPEI_ADDR_CCS:  bus_rdata_q <= {`FPEI_CCS_FIXED, err,
                                     `FPEI_CCS_RSVD_LOW, 1'b0}; // [RULE_03] [RULE_04] [RULE_05] [RULE_06]
                    `FPEI_ADDR_PCS:  bus_rdata_q <= pcs_q;
                    `FPEI_ADDR_ECS:  bus_rdata_q <= ecs_q;
                    `FPEI_ADDR_KEY:  bus_rdata_q <= key_q;
                    `FPEI_ADDR_MATS: bus_rdata_q <= mats_q;
                    `FPEI_ADDR_TDAR: bus_rdata_q <= tdar_q;
                    default:         bus_hit_q   <= 1'b0;
                endcase
            end
            copy_busy_q    <= active;
            copy_program_q <= active & pcs_q[`FPEI_BIT_CHOOSE];
            copy_erase_q   <= active & ecs_q[`FPEI_BIT_CHOOSE];
            // Result byte: 0x00 on success, 0x01 if no single routine chosen
            result_we_q    <= done; // [RULE_14]
            result_addr_q  <= tdar_q;
            result_data_q  <= {7'h00, ~sel_ok_q};
            pe_allow_q     <= pe_request && !err
                              && (key_q == `FPEI_KEY_ENABLE); // [RULE_19]
            protect_q      <= err; // [RULE_06]
        end
    end
endmodule // fpei_top
`default_nettype wire

// ===== tb/fpei_checker.sv
// Assertions on the ports of fpei_top.
// Assumes a single sys_clk domain; bound to every fpei_top.
`default_nettype none
module fpei_checker #(parameter [15:0] COPY_CYCLES = 16'h0100) (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic [15:0] bus_addr,
    input wire logic        bus_rd,
    input wire logic [1:0]  bus_size,
    input wire logic        pe_running,
    input wire logic        irq_accept,
    input wire logic        array_read,
    input wire logic        sleep_exec,
    input wire logic [7:0]  bus_rdata_q,
    input wire logic        bus_hit_q,
    input wire logic        copy_busy_q,
    input wire logic        result_we_q,
    input wire logic        pe_allow_q,
    input wire logic        protect_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    chk_err_sticky: assert property (protect_q |=> protect_q)
        else $error("error flag dropped");
    chk_irq_sets: assert property (pe_running && irq_accept |-> ##2 protect_q)
        else $error("irq did not set error");
    chk_read_sets: assert property (pe_running && array_read |-> ##2 protect_q)
        else $error("array read did not set error");
    chk_sleep_sets: assert property (pe_running && sleep_exec |-> ##2 protect_q)
        else $error("sleep did not set error");
    chk_err_cause: assert property ($rose(protect_q) |-> $past(pe_running
        && (irq_accept || array_read || sleep_exec), 2))
        else $error("error flag set without cause");
    chk_prot_block: assert property (protect_q |-> !pe_allow_q)
        else $error("operation allowed while protected");
    chk_ccs_read: assert property (bus_hit_q && $past(bus_addr) == 16'hFEA8
        |-> bus_rdata_q == {3'h4, protect_q, 4'h0})
        else $error("status read wrong");
    chk_byte_only: assert property (bus_rd && bus_size != 2'h0 |=> !bus_hit_q)
        else $error("wide access answered");
    chk_done_pulse: assert property ($fell(copy_busy_q)
        |-> result_we_q ##1 !result_we_q)
        else $error("no single result write at end of copy");
    cover property (result_we_q);
    cover property ($rose(protect_q));
    cover property (bus_hit_q && $past(bus_addr) == 16'hFEA8);
endmodule // fpei_checker
bind fpei_top fpei_checker #(.COPY_CYCLES(COPY_CYCLES)) chk_i (
    .sys_clk, .reset, .bus_addr, .bus_rd, .bus_size, .pe_running,
    .irq_accept, .array_read, .sleep_exec, .bus_rdata_q, .bus_hit_q,
    .copy_busy_q, .result_we_q, .pe_allow_q, .protect_q);
`default_nettype wire

// ===== tb/test_flash_program_erase_interface.sv
// Self-checking bench for fpei_top: registers, download, error latch.
// Assumes the design and the checker are compiled before it.
`default_nettype none
module test_flash_program_erase_interface;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, reset = 1, bus_wr = 0, bus_rd = 0, fram = 0;
    logic pe_running = 0, pe_request = 0;
    logic [15:0] bus_addr = 16'h0000;
    logic [1:0] bus_size = 2'h0;
    logic [2:0] ev = 3'h0;
    logic [7:0] bus_wdata = 8'h00, d, rdata, raddr, rres;
    logic hit, busy, prog, ers, we, allow, prot;
    logic [7:0] exp_q[$];
    logic [15:0] regs[5] = '{16'hFEA9, 16'hFEAA, 16'hFEAC, 16'hFEAD, 16'hFEAE};
    logic [7:0] msk[5] = '{8'h01, 8'h01, 8'hFF, 8'hFF, 8'hFF};
    int miscompares = 0, checks = 0, i;
    always #5 sys_clk = ~sys_clk;
    // Short copy time keeps the download scenario brief
    fpei_top #(.COPY_CYCLES(16'h0010)) uut (.sys_clk(sys_clk), .reset(reset),
        .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_size(bus_size), .bus_wdata(bus_wdata), .fetch_from_ram(fram),
        .pe_running(pe_running), .pe_request(pe_request),
        .irq_accept(ev[0]), .array_read(ev[1]), .sleep_exec(ev[2]),
        .bus_rdata_q(rdata), .bus_hit_q(hit), .copy_busy_q(busy),
        .copy_program_q(prog), .copy_erase_q(ers), .result_addr_q(raddr),
        .result_we_q(we), .result_data_q(rres), .pe_allow_q(allow),
        .protect_q(prot));
    task automatic fail(string m);
        miscompares++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic cmp_rd(logic [7:0] g, logic [7:0] e);
        checks++;
        if (g !== e) fail($sformatf("data %h expected %h", g, e));
    endtask
    task automatic cmp_flag(logic g, logic e);
        checks++;
        if (g !== e) fail("flag mismatch");
    endtask
    task automatic finish_test;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] v);
        @(negedge sys_clk);
        bus_addr = a;
        bus_wdata = v;
        bus_wr = 1;
        @(negedge sys_clk);
        bus_wr = 0;
    endtask
    // Only mapped byte reads leave a note for the monitor
    task automatic rd(logic [15:0] a, logic [7:0] e, bit mapped = 1);
        @(negedge sys_clk);
        bus_addr = a;
        bus_rd = 1;
        if (mapped) exp_q.push_back(e);
        @(negedge sys_clk);
        bus_rd = 0;
    endtask
    task automatic do_reset(int n);
        reset = 1;
        repeat (n) @(negedge sys_clk);
        reset = 0;
    endtask
    always @(negedge sys_clk)
        if (hit === 1'b1) begin
            if (exp_q.size() == 0) fail("unexpected read answer");
            else cmp_rd(rdata, exp_q.pop_front());
        end
    initial begin
        void'($urandom(32'h9FAF));
        do_reset(4);
        rd(16'hFEA8, 8'h80);
        foreach (regs[k]) rd(regs[k], 8'h00);
        rd(16'hFEAB, 8'h00, 0);
        foreach (regs[k]) begin
            d = 8'($urandom);
            wr(regs[k], d);
            rd(regs[k], d & msk[k]);
        end
        bus_size = 2'h1;
        wr(16'hFEAE, ~d);
        rd(16'hFEA8, 8'h00, 0);
        bus_size = 2'h0;
        rd(16'hFEAE, d);
        wr(16'hFEA8, 8'hFE);
        rd(16'hFEA8, 8'h80);
        $display("test registers done");
        wr(16'hFEAC, 8'h00);
        wr(16'hFEAA, 8'h00);
        wr(16'hFEA9, 8'h01);
        wr(16'hFEA8, 8'h01);
        repeat (8) @(negedge sys_clk);
        rd(16'hFEA9, 8'h01);
        fram = 1;
        wr(16'hFEAC, 8'hA5);
        wr(16'hFEAE, 8'h40);
        for (int k = 0; k < 2; k++) begin
            wr(16'(16'hFEA9 + k), 8'h01);
            wr(16'hFEA8, 8'h01);
            repeat (2) @(negedge sys_clk);
            cmp_flag(k ? ers : prog, 1'b1);
            rd(16'hFEA8, 8'h80);
            rd(16'hFEA8, 8'h80);
            for (i = 0; i < 40 && we !== 1'b1; i++) @(negedge sys_clk);
            if (we !== 1'b1) begin
                fail("copy never finished");
                finish_test();
            end
            cmp_rd(raddr, 8'h40);
            cmp_rd(rres, 8'h00);
            cmp_flag(busy, 1'b0);
            rd(16'(16'hFEA9 + k), 8'h00);
        end
        $display("test download done");
        for (int k = 0; k < 3; k++) begin
            pe_request = 1;
            wr(16'hFEAD, 8'h01);
            wr(16'hFEAC, 8'hA5);
            repeat (2) @(negedge sys_clk);
            cmp_flag(allow, 1'b1);
            // Routine parameters sit in CPU registers, outside this block
            pe_running = 1;
            ev = 3'h1 << k;
            @(negedge sys_clk);
            ev = 3'h0;
            repeat (2) @(negedge sys_clk);
            cmp_flag(prot, 1'b1);
            pe_running = 0;
            cmp_flag(allow, 1'b0);
            rd(16'hFEA8, 8'h90);
            wr(16'hFEA8, 8'h01);
            repeat (2) @(negedge sys_clk);
            cmp_flag(busy, 1'b0);
            // Long hold after an error spares the array; costs run time
            do_reset(10000);
            cmp_flag(prot, 1'b0);
        end
        $display("test errors done");
        finish_test();
    end
endmodule // test_flash_program_erase_interface
`default_nettype wire
